// *** pkg/arith_decode_regs.vh ***
// Purpose: Opcode patterns, class codes and clock counts for the
//          arithmetic instruction decoder.
// Assumes: Included by the decoder, its assertion monitor and its testbench.
// Notes:   Patterns with wildcards are binary so casez can use them.
`ifndef ARITH_DECODE_REGS_VH
`define ARITH_DECODE_REGS_VH

// First-byte patterns and the adjust second byte
`define PAT_ADC_RM     8'b0001_00??
`define PAT_ADC_ACC    8'b0001_010?
`define PAT_SUB_RM     8'b0010_10??
`define PAT_SWB_RM     8'b0001_10??
`define PAT_SWB_ACC    8'b0001_110?
`define PAT_GRP_IMM    8'b1000_00??
`define PAT_GRP_MULDIV 8'b1111_011?
`define PAT_GRP_INCDEC 8'b1111_111?
`define PAT_INC_SHORT  8'b0100_0???
`define PAT_DCR_SHORT  8'b0100_1???
`define PAT_SMUL_IMM   8'b0110_10?1
`define OPC_ASCII_SUB_ADJ 8'h3F
`define OPC_BCD_SUB_ADJ   8'h2F
`define OPC_ASCII_ADD_ADJ 8'h37
`define OPC_BCD_ADD_ADJ   8'h27
`define OPC_ASCII_DIV_ADJ 8'hD5
`define OPC_ASCII_MPY_ADJ 8'hD4
`define OPC_ADJ_SECOND    8'h0A
`define OPC_BYTE_TO_WORD  8'h98
`define OPC_WORD_TO_DWORD 8'h99

// Middle-field values of the ModR/M byte
`define MID_ADC    3'h2
`define MID_SUB    3'h5
`define MID_SWB    3'h3
`define MID_INC    3'h0
`define MID_DCR    3'h1
`define MID_UMUL   3'h4
`define MID_SMUL   3'h5
`define MID_UDIV   3'h6
`define MID_SDIV   3'h7

// Operation classes
`define CLS_ADD_CARRY   5'h00
`define CLS_INCREMENT   5'h01
`define CLS_SUBTRACT    5'h02
`define CLS_SUB_BORROW  5'h03
`define CLS_DECREMENT   5'h04
`define CLS_UMUL        5'h05
`define CLS_SMUL        5'h06
`define CLS_SMUL_IMM    5'h07
`define CLS_UDIV        5'h08
`define CLS_SDIV        5'h09
`define CLS_ASCII_SUB   5'h0A
`define CLS_BCD_SUB     5'h0B
`define CLS_ASCII_ADD   5'h0C
`define CLS_BCD_ADD     5'h0D
`define CLS_ASCII_DIV   5'h0E
`define CLS_ASCII_MPY   5'h0F
`define CLS_BYTE_WORD   5'h10
`define CLS_WORD_DWORD  5'h11

// Operand forms
`define FORM_FIXED  3'h0
`define FORM_RMREG  3'h1
`define FORM_RMIMM  3'h2
`define FORM_ACC    3'h3
`define FORM_SHORT  3'h4

// Groups resolved by the ModR/M middle field
`define GRP_NONE   2'h0
`define GRP_IMM    2'h1
`define GRP_MULDIV 2'h2
`define GRP_INCDEC 2'h3

// Execution clock counts
`define CLK_REG        6'h01
`define CLK_MEM_RMREG  6'h07
`define CLK_MEM_RMIMM  6'h08
`define CLK_UMUL_RB    6'h0D
`define CLK_UMUL_RW    6'h15
`define CLK_UMUL_MB    6'h12
`define CLK_UMUL_MW    6'h1A
`define CLK_SMUL_RB    6'h10
`define CLK_SMUL_RW    6'h18
`define CLK_SMUL_MB    6'h15
`define CLK_SMUL_MW    6'h1D
`define CLK_SMULI_R    6'h17
`define CLK_SMULI_M    6'h1C
`define CLK_DIV_RB     6'h12
`define CLK_DIV_RW     6'h1A
`define CLK_DIV_MB     6'h17
`define CLK_DIV_MW     6'h1F
`define CLK_ASCII_SUB  6'h03
`define CLK_BCD_SUB    6'h02
`define CLK_ASCII_ADD  6'h03
`define CLK_BCD_ADD    6'h02
`define CLK_ASCII_DIV  6'h0E
`define CLK_ASCII_MPY  6'h0F
`define CLK_EXTEND     6'h02

`endif

// *** rtl/exec_timer.v ***
// Purpose: Counts the execution clocks of one decoded instruction.
// Assumes: start is a one-cycle pulse; loadCount is at least one.
// Notes:   busy lasts exactly loadCount cycles after the start edge.
`timescale 1ns/1ns
module exec_timer
(
   input  wire       sys_clk,
   input  wire       rst,
   input  wire       start,
   input  wire [5:0] loadCount,
   output wire       busy,
   output wire       done
);
   reg [5:0] remain;

   always @(posedge sys_clk)
   begin
      if (rst)
         remain <= 6'h00;
      else if (start)
         remain <= loadCount;
      else if (remain != 6'h00)
         remain <= remain - 6'h01;
   end

   assign busy = (remain != 6'h00);
   // Last cycle of the count
   assign done = (remain == 6'h01);
endmodule

// *** rtl/arith_instr_decode_timing.v ***
// Purpose: Decodes the arithmetic instruction group from a byte stream
//          and holds the core busy for each instruction's clock count.
// Assumes: Bytes come from same-clock fetch logic; valid/ready handshake.
// Notes:   Unknown or foreign opcodes raise unsupportedOp and are dropped.
// What this block does
// - add-with-carry in three forms, register form one clock.
// - short increment 01000+reg takes one clock; reg/mem form 1 or 8.
// - subtract reg/mem form 1 or 7; immediate field 101 takes 1 or 8.
// - subtract-with-borrow register form and immediate field 011.
// - short decrement 01001+reg one clock; reg/mem form field 001.
// - unsigned multiply field 100: 13, 21, 18, 26 clocks.
// - signed multiply field 101: 16, 24, 21, 29 clocks.
// - multiply by immediate 011010s1, second data byte if s is 0.
// - divide fields 110 and 111: 18, 26, 23, 31 clocks.
// - ascii subtract adjust 00111111 takes 3 clocks.
// - decimal subtract adjust takes 2 clocks; its opcode is resolved.
// - ascii add adjust 00110111 takes 3 clocks.
// - decimal add adjust 00100111 takes 2 clocks.
// - ascii divide adjust 11010101 then 00001010, 14 clocks.
// - ascii multiply adjust 11010100 then 00001010, 15 clocks.
// - byte-to-word extend 10011000 takes 2 clocks.
// - word-to-dword extend 10011001 takes 2 clocks.
`timescale 1ns/1ns
`include "arith_decode_regs.vh"
module arith_instr_decode_timing
(
   input  wire        sys_clk,
   input  wire        rst,
   input  wire [7:0]  byteData,
   input  wire        byteValid,
   output wire        byteReady,
   output reg         opValid,
   output reg  [4:0]  opClass,
   output reg  [2:0]  opForm,
   output reg         opWord,
   output reg         opToReg,
   output reg         opSignExt,
   output reg         opMemory,
   output reg  [1:0]  opMod,
   output reg  [2:0]  opReg,
   output reg  [2:0]  opRm,
   output reg  [15:0] opDisp,
   output reg  [15:0] opImm,
   output reg  [5:0]  opClocks,
   output reg         unsupportedOp,
   output wire        execBusy,
   output wire        execDone
);
   localparam S_OPC    = 3'h0;
   localparam S_SECOND = 3'h1;
   localparam S_MODRM  = 3'h2;
   localparam S_DISP   = 3'h3;
   localparam S_IMM    = 3'h4;
   localparam S_LAUNCH = 3'h5;
   localparam S_EXEC   = 3'h6;

   reg  [2:0] st;
   reg  [1:0] group;
   reg  [1:0] dispLeft;
   reg  [1:0] dispTotal;
   reg  [1:0] immLeft;
   reg  [1:0] immTotal;
   reg        launch;

   reg        fKnown;
   reg  [4:0] fCls;
   reg  [2:0] fForm;
   reg        fModrm;
   reg  [1:0] fGroup;
   reg  [1:0] fImm;
   reg        fSecond;
   reg        fWord;
   reg        fSext;

   wire       accept;
   wire [5:0] grpRes;
   wire [1:0] mDisp;
   wire       mMem;

   // Data bytes after the ModR/M: two only when s=0 and w=1
   function [1:0] immSw;
      input s;
      input w;
      begin
         immSw = (!s && w) ? 2'h2 : 2'h1;
      end
   endfunction

   function [1:0] dispCount;
      input [1:0] md;
      input [2:0] rm;
      begin
         if (md == 2'h1)
            dispCount = 2'h1;
         else if (md == 2'h2 || (md == 2'h0 && rm == 3'h6))
            dispCount = 2'h2;
         else
            dispCount = 2'h0;
      end
   endfunction

   // Low byte widened: sign-extended when asked, else zero-filled
   function [15:0] widen;
      input [7:0] b;
      input       sext;
      begin
         widen = {(sext ? {8{b[7]}} : 8'h00), b};
      end
   endfunction

   // Returns {known, class} for a group resolved by the middle field
   function [5:0] groupClass;
      input [1:0] grp;
      input [2:0] mid;
      begin
         groupClass = 6'h00;
         case (grp)
            `GRP_IMM:
            begin
               if (mid == `MID_ADC)
                  groupClass = {1'b1, `CLS_ADD_CARRY};
               else if (mid == `MID_SUB)
                  groupClass = {1'b1, `CLS_SUBTRACT};
               else if (mid == `MID_SWB)
                  groupClass = {1'b1, `CLS_SUB_BORROW};
            end
            `GRP_MULDIV:
            begin
               if (mid == `MID_UMUL)
                  groupClass = {1'b1, `CLS_UMUL};
               else if (mid == `MID_SMUL)
                  groupClass = {1'b1, `CLS_SMUL};
               else if (mid == `MID_UDIV)
                  groupClass = {1'b1, `CLS_UDIV};
               else if (mid == `MID_SDIV)
                  groupClass = {1'b1, `CLS_SDIV};
            end
            `GRP_INCDEC:
            begin
               if (mid == `MID_INC)
                  groupClass = {1'b1, `CLS_INCREMENT};
               else if (mid == `MID_DCR)
                  groupClass = {1'b1, `CLS_DECREMENT};
            end
            default:
               groupClass = 6'h00;
         endcase
      end
   endfunction

   function [5:0] clocksFor;
      input [4:0] cls;
      input [2:0] form;
      input       mem;
      input       word;
      begin
         case (cls)
            `CLS_ADD_CARRY, `CLS_SUBTRACT, `CLS_SUB_BORROW:
               if (mem && form == `FORM_RMIMM)
                  clocksFor = `CLK_MEM_RMIMM;
               else if (mem)
                  clocksFor = `CLK_MEM_RMREG;
               else
                  clocksFor = `CLK_REG;
            `CLS_INCREMENT, `CLS_DECREMENT:
               clocksFor = mem ? `CLK_MEM_RMIMM : `CLK_REG;
            `CLS_UMUL:
               clocksFor = mem ? (word ? `CLK_UMUL_MW : `CLK_UMUL_MB)
                               : (word ? `CLK_UMUL_RW : `CLK_UMUL_RB);
            `CLS_SMUL:
               clocksFor = mem ? (word ? `CLK_SMUL_MW : `CLK_SMUL_MB)
                               : (word ? `CLK_SMUL_RW : `CLK_SMUL_RB);
            `CLS_SMUL_IMM:
               clocksFor = mem ? `CLK_SMULI_M : `CLK_SMULI_R;
            `CLS_UDIV, `CLS_SDIV:
               clocksFor = mem ? (word ? `CLK_DIV_MW : `CLK_DIV_MB)
                               : (word ? `CLK_DIV_RW : `CLK_DIV_RB);
            `CLS_ASCII_SUB:
               clocksFor = `CLK_ASCII_SUB;
            `CLS_BCD_SUB:
               clocksFor = `CLK_BCD_SUB;
            `CLS_ASCII_ADD:
               clocksFor = `CLK_ASCII_ADD;
            `CLS_BCD_ADD:
               clocksFor = `CLK_BCD_ADD;
            `CLS_ASCII_DIV:
               clocksFor = `CLK_ASCII_DIV;
            `CLS_ASCII_MPY:
               clocksFor = `CLK_ASCII_MPY;
            `CLS_BYTE_WORD, `CLS_WORD_DWORD:
               clocksFor = `CLK_EXTEND;
            default:
               clocksFor = `CLK_REG;
         endcase
      end
   endfunction

   // First-byte decode
   always @*
   begin
      fKnown  = 1'b1;
      fCls    = `CLS_ADD_CARRY;
      fForm   = `FORM_FIXED;
      fModrm  = 1'b0;
      fGroup  = `GRP_NONE;
      fImm    = 2'h0;
      fSecond = 1'b0;
      fWord   = byteData[0];
      fSext   = 1'b0;
      casez (byteData)
         `PAT_ADC_RM:
         begin
            fForm  = `FORM_RMREG;
            fModrm = 1'b1;
         end
         `PAT_ADC_ACC:
         begin
            fForm = `FORM_ACC;
            fImm  = byteData[0] ? 2'h2 : 2'h1;
         end
         `PAT_SUB_RM:
         begin
            fCls   = `CLS_SUBTRACT;
            fForm  = `FORM_RMREG;
            fModrm = 1'b1;
         end
         `PAT_SWB_RM:
         begin
            fCls   = `CLS_SUB_BORROW;
            fForm  = `FORM_RMREG;
            fModrm = 1'b1;
         end
         `PAT_SWB_ACC:
         begin
            fCls  = `CLS_SUB_BORROW;
            fForm = `FORM_ACC;
            fImm  = byteData[0] ? 2'h2 : 2'h1;
         end
         `PAT_GRP_IMM:
         begin
            fForm  = `FORM_RMIMM;
            fModrm = 1'b1;
            fGroup = `GRP_IMM;
            fSext  = byteData[1];
            fImm   = immSw(byteData[1], byteData[0]);
         end
         `PAT_GRP_MULDIV:
         begin
            fForm  = `FORM_RMREG;
            fModrm = 1'b1;
            fGroup = `GRP_MULDIV;
         end
         `PAT_GRP_INCDEC:
         begin
            fForm  = `FORM_RMREG;
            fModrm = 1'b1;
            fGroup = `GRP_INCDEC;
         end
         `PAT_INC_SHORT:
         begin
            fCls  = `CLS_INCREMENT;
            fForm = `FORM_SHORT;
            fWord = 1'b1;
         end
         `PAT_DCR_SHORT:
         begin
            fCls  = `CLS_DECREMENT;
            fForm = `FORM_SHORT;
            fWord = 1'b1;
         end
         `PAT_SMUL_IMM:
         begin
            fCls   = `CLS_SMUL_IMM;
            fForm  = `FORM_RMIMM;
            fModrm = 1'b1;
            fSext  = byteData[1];
            fImm   = byteData[1] ? 2'h1 : 2'h2;
         end
         `OPC_ASCII_SUB_ADJ: fCls = `CLS_ASCII_SUB;
         `OPC_BCD_SUB_ADJ:   fCls = `CLS_BCD_SUB;
         `OPC_ASCII_ADD_ADJ: fCls = `CLS_ASCII_ADD;
         `OPC_BCD_ADD_ADJ:   fCls = `CLS_BCD_ADD;
         `OPC_BYTE_TO_WORD:  fCls = `CLS_BYTE_WORD;
         `OPC_WORD_TO_DWORD: fCls = `CLS_WORD_DWORD;
         `OPC_ASCII_DIV_ADJ:
         begin
            fCls    = `CLS_ASCII_DIV;
            fSecond = 1'b1;
         end
         `OPC_ASCII_MPY_ADJ:
         begin
            fCls    = `CLS_ASCII_MPY;
            fSecond = 1'b1;
         end
         default:
            fKnown = 1'b0;
      endcase
   end

   assign byteReady = (st == S_OPC) || (st == S_SECOND) ||
                      (st == S_MODRM) || (st == S_DISP) || (st == S_IMM);
   assign accept = byteValid && byteReady;
   assign grpRes = groupClass(group, byteData[5:3]);
   assign mDisp  = dispCount(byteData[7:6], byteData[2:0]);
   assign mMem   = (byteData[7:6] != 2'h3);

   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         st            <= S_OPC;
         group         <= `GRP_NONE;
         dispLeft      <= 2'h0;
         dispTotal     <= 2'h0;
         immLeft       <= 2'h0;
         immTotal      <= 2'h0;
         launch        <= 1'b0;
         opValid       <= 1'b0;
         opClass       <= `CLS_ADD_CARRY;
         opForm        <= `FORM_FIXED;
         opWord        <= 1'b0;
         opToReg       <= 1'b0;
         opSignExt     <= 1'b0;
         opMemory      <= 1'b0;
         opMod         <= 2'h0;
         opReg         <= 3'h0;
         opRm          <= 3'h0;
         opDisp        <= 16'h0000;
         opImm         <= 16'h0000;
         opClocks      <= 6'h00;
         unsupportedOp <= 1'b0;
      end
      else
      begin
         launch        <= 1'b0;
         opValid       <= 1'b0;
         unsupportedOp <= 1'b0;
         case (st)
            S_OPC:
               if (accept)
               begin
                  opClass   <= fCls;
                  opForm    <= fForm;
                  opWord    <= fWord;
                  opToReg   <= byteData[1];
                  opSignExt <= fSext;
                  opMemory  <= 1'b0;
                  opMod     <= 2'h3;
                  opReg     <= byteData[2:0];
                  opRm      <= byteData[2:0];
                  opDisp    <= 16'h0000;
                  opImm     <= 16'h0000;
                  group     <= fGroup;
                  immLeft   <= fImm;
                  immTotal  <= fImm;
                  if (!fKnown)
                     unsupportedOp <= 1'b1;
                  else if (fSecond)
                     st <= S_SECOND;
                  else if (fModrm)
                     st <= S_MODRM;
                  else if (fImm != 2'h0)
                     st <= S_IMM;
                  else
                     st <= S_LAUNCH;
               end
            S_SECOND:
               if (accept)
               begin
                  if (byteData == `OPC_ADJ_SECOND)
                     st <= S_LAUNCH;
                  else
                  begin
                     unsupportedOp <= 1'b1;
                     st            <= S_OPC;
                  end
               end
            S_MODRM:
               if (accept)
               begin
                  opMod     <= byteData[7:6];
                  opReg     <= byteData[5:3];
                  opRm      <= byteData[2:0];
                  opMemory  <= mMem;
                  dispLeft  <= mDisp;
                  dispTotal <= mDisp;
                  if (group != `GRP_NONE)
                     opClass <= grpRes[4:0];
                  if (group != `GRP_NONE && !grpRes[5])
                  begin
                     unsupportedOp <= 1'b1;
                     st            <= S_OPC;
                  end
                  else if (mDisp != 2'h0)
                     st <= S_DISP;
                  else if (immLeft != 2'h0)
                     st <= S_IMM;
                  else
                     st <= S_LAUNCH;
               end
            S_DISP:
               if (accept)
               begin
                  if (dispLeft == dispTotal)
                     opDisp <= widen(byteData, dispTotal == 2'h1);
                  else
                     opDisp <= {byteData, opDisp[7:0]};
                  dispLeft <= dispLeft - 2'h1;
                  if (dispLeft == 2'h1)
                     st <= (immLeft != 2'h0) ? S_IMM : S_LAUNCH;
               end
            S_IMM:
               if (accept)
               begin
                  if (immLeft == immTotal)
                     opImm <= widen(byteData, opSignExt);
                  else
                     opImm <= {byteData, opImm[7:0]};
                  immLeft <= immLeft - 2'h1;
                  if (immLeft == 2'h1)
                     st <= S_LAUNCH;
               end
            S_LAUNCH:
            begin
               opClocks <= clocksFor(opClass, opForm, opMemory, opWord);
               opValid  <= 1'b1;
               launch   <= 1'b1;
               st       <= S_EXEC;
            end
            S_EXEC:
               if (execDone)
                  st <= S_OPC;
            default:
               st <= S_OPC;
         endcase
      end
   end

   exec_timer timer
   (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .start     (launch),
      .loadCount (opClocks),
      .busy      (execBusy),
      .done      (execDone)
   );
endmodule

// *** verification/arith_decode_monitor.sv ***
// Purpose: Port assertions for the arithmetic decoder and its timer.
// Assumes: Single clock domain, synchronous active-high reset.
// Notes:   left follows the busy span expected from opClocks.
`timescale 1ns/1ns
`include "arith_decode_regs.vh"
module arith_decode_monitor
(
   input wire       sys_clk,
   input wire       rst,
   input wire       byteReady,
   input wire       opValid,
   input wire [4:0] opClass,
   input wire [2:0] opForm,
   input wire       opWord,
   input wire [1:0] opMod,
   input wire [5:0] opClocks,
   input wire       unsupportedOp,
   input wire       execBusy,
   input wire       execDone
);
   reg [5:0] left;
   wire      regOp = opMod == 2'h3;

   always @(posedge sys_clk)
   begin
      if (rst)
         left <= 6'h00;
      else if (opValid)
         left <= opClocks;
      else if (left != 6'h00)
         left <= left - 6'h01;
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   AST_BUSY_SPAN: assert property (execBusy == (left != 6'h00))
      else $error("busy span differs from clock count");
   AST_DONE_LAST: assert property (execDone == (left == 6'h01))
      else $error("done not in last busy cycle");
   AST_START: assert property (opValid |=> execBusy && !opValid)
      else $error("busy did not follow decode");
   AST_HOLD: assert property ((opValid || execBusy) |-> !byteReady)
      else $error("byte taken while executing");
   AST_READY: assert property ($fell(execBusy) |-> byteReady)
      else $error("ready missing after execution");
   AST_SHORT: assert property (opValid && opForm == `FORM_SHORT
      |-> opClocks == 6'h01) else $error("short form clocks");
   AST_UMUL: assert property (opValid && opClass == `CLS_UMUL
      && regOp && !opWord |-> opClocks == 6'h0D) else $error("umul clocks");
   AST_SMUL: assert property (opValid && opClass == `CLS_SMUL
      && !regOp && opWord |-> opClocks == 6'h1D) else $error("smul clocks");
   AST_DIV: assert property (opValid && regOp && !opWord
      && (opClass == `CLS_UDIV || opClass == `CLS_SDIV)
      |-> opClocks == 6'h12) else $error("div clocks");
   AST_ADJ: assert property (opValid && opClass == `CLS_ASCII_MPY
      |-> opClocks == 6'h0F) else $error("multiply adjust clocks");
   AST_DROP: assert property (unsupportedOp |-> byteReady && !opValid)
      else $error("dropped byte left decoder busy");

   cover property (opValid && opClass == `CLS_SMUL_IMM);
   cover property (unsupportedOp);
   cover property (execDone && opClocks == 6'h1F);
endmodule

bind arith_instr_decode_timing arith_decode_monitor mon
(
   .sys_clk(sys_clk), .rst(rst), .byteReady(byteReady),
   .opValid(opValid), .opClass(opClass), .opForm(opForm),
   .opWord(opWord), .opMod(opMod), .opClocks(opClocks),
   .unsupportedOp(unsupportedOp), .execBusy(execBusy),
   .execDone(execDone)
);

// *** verification/tb_arith_instr_decode_timing.sv ***
// Purpose: Self-checking bench for the arithmetic decoder.
// Assumes: Class and form codes come from the shared header.
// Notes:   Byte vectors hold the first instruction byte lowest.
`timescale 1ns/1ns
`include "arith_decode_regs.vh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_mismatch++; \
   $display("Error t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_arith_instr_decode_timing;
   reg         sys_clk, rst, byteValid;
   reg  [7:0]  byteData;
   wire        byteReady, opValid, opWord, opToReg, opSignExt, opMemory;
   wire        unsupportedOp, execBusy, execDone;
   wire [4:0]  opClass;
   wire [2:0]  opForm, opReg, opRm;
   wire [1:0]  opMod;
   wire [15:0] opDisp, opImm;
   wire [5:0]  opClocks;
   int         n_mismatch = 0;
   int         n_tests = 0;

   arith_instr_decode_timing dut
   (
      .sys_clk(sys_clk), .rst(rst), .byteData(byteData),
      .byteValid(byteValid), .byteReady(byteReady), .opValid(opValid),
      .opClass(opClass), .opForm(opForm), .opWord(opWord),
      .opToReg(opToReg), .opSignExt(opSignExt), .opMemory(opMemory),
      .opMod(opMod), .opReg(opReg), .opRm(opRm), .opDisp(opDisp),
      .opImm(opImm), .opClocks(opClocks), .unsupportedOp(unsupportedOp),
      .execBusy(execBusy), .execDone(execDone)
   );

   initial
   begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   task automatic test_done;
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Offers n bytes back to back, each held until taken
   task automatic send(input [47:0] b, input int n);
      int i;
      int g;
      reg r;
      for (i = 0; i < n; i++)
      begin
         byteValid <= 1'b1;
         byteData  <= b[8*i +: 8];
         g = 0;
         do
         begin
            @(negedge sys_clk);
            r = byteReady;
            @(posedge sys_clk);
            g++;
         end
         while (r !== 1'b1 && g < 60);
      end
      byteValid <= 1'b0;
   endtask

   task automatic op(input [47:0] b, input int n, input [4:0] c,
                     input [5:0] k);
      int g;
      reg [5:0] cnt;
      send(b, n);
      g = 0;
      do
      begin
         @(negedge sys_clk);
         g++;
      end
      while (opValid !== 1'b1 && g < 8);
      `CHK(opValid, 1'b1);
      `CHK(opClass, c);
      `CHK(opClocks, k);
      cnt = 6'h00;
      do
      begin
         @(negedge sys_clk);
         g++;
         if (execBusy === 1'b1)
            cnt = cnt + 6'h01;
      end
      while (byteReady !== 1'b1 && g < 60);
      `CHK(cnt, k);
      @(posedge sys_clk);
   endtask

   task automatic bad(input [15:0] b, input int n);
      send({32'h0000_0000, b}, n);
      @(negedge sys_clk);
      `CHK(unsupportedOp, 1'b1);
      `CHK(byteReady, 1'b1);
      @(posedge sys_clk);
   endtask

   task automatic t_add_carry;
      op(48'hC010, 2, `CLS_ADD_CARRY, 6'h01);
      op(48'h3412_0611, 4, `CLS_ADD_CARRY, 6'h07);
      op(48'h5678_1234_1681, 6, `CLS_ADD_CARRY, 6'h08);
      op(48'h12_3415, 3, `CLS_ADD_CARRY, 6'h01);
   endtask

   task automatic t_sub;
      op(48'hC028, 2, `CLS_SUBTRACT, 6'h01);
      op(48'hF0_4629, 3, `CLS_SUBTRACT, 6'h07);
      op(48'h01_E883, 3, `CLS_SUBTRACT, 6'h01);
      op(48'h0110_6E83, 4, `CLS_SUBTRACT, 6'h08);
      op(48'hC018, 2, `CLS_SUB_BORROW, 6'h01);
      op(48'h01_D883, 3, `CLS_SUB_BORROW, 6'h01);
      op(48'h12_341D, 3, `CLS_SUB_BORROW, 6'h01);
      `CHK({opForm, opImm}, {`FORM_ACC, 16'h1234});
   endtask

   task automatic t_incdec;
      op(48'h40, 1, `CLS_INCREMENT, 6'h01);
      op(48'h4F, 1, `CLS_DECREMENT, 6'h01);
      op(48'hC0FE, 2, `CLS_INCREMENT, 6'h01);
      op(48'h3412_06FF, 4, `CLS_INCREMENT, 6'h08);
      op(48'h10_4EFF, 3, `CLS_DECREMENT, 6'h08);
   endtask

   task automatic t_muldiv;
      op(48'hE0F6, 2, `CLS_UMUL, 6'h0D);
      op(48'hE0F7, 2, `CLS_UMUL, 6'h15);
      op(48'h3412_26F6, 4, `CLS_UMUL, 6'h12);
      op(48'h10_66F7, 3, `CLS_UMUL, 6'h1A);
      op(48'hE8F6, 2, `CLS_SMUL, 6'h10);
      op(48'hE8F7, 2, `CLS_SMUL, 6'h18);
      op(48'h3412_2EF6, 4, `CLS_SMUL, 6'h15);
      op(48'h10_6EF7, 3, `CLS_SMUL, 6'h1D);
      op(48'hF0F6, 2, `CLS_UDIV, 6'h12);
      op(48'hF8F7, 2, `CLS_SDIV, 6'h1A);
      op(48'h3412_36F6, 4, `CLS_UDIV, 6'h17);
      op(48'h10_7EF7, 3, `CLS_SDIV, 6'h1F);
   endtask

   task automatic t_adjust;
      op(48'h3F, 1, `CLS_ASCII_SUB, 6'h03);
      op(48'h2F, 1, `CLS_BCD_SUB, 6'h02);
      op(48'h37, 1, `CLS_ASCII_ADD, 6'h03);
      op(48'h27, 1, `CLS_BCD_ADD, 6'h02);
      op(48'h0AD5, 2, `CLS_ASCII_DIV, 6'h0E);
      op(48'h0AD4, 2, `CLS_ASCII_MPY, 6'h0F);
      op(48'h98, 1, `CLS_BYTE_WORD, 6'h02);
      op(48'h99, 1, `CLS_WORD_DWORD, 6'h02);
   endtask

   task automatic t_fields;
      op(48'hFF_D083, 3, `CLS_ADD_CARRY, 6'h01);
      `CHK({opSignExt, opWord, opImm}, 18'h3_FFFF);
      op(48'h85_D080, 3, `CLS_ADD_CARRY, 6'h01);
      `CHK({opSignExt, opWord, opImm}, 18'h0_0085);
      op(48'hC012, 2, `CLS_ADD_CARRY, 6'h01);
      `CHK({opToReg, opWord, opMemory}, 3'h4);
      op(48'h80_C06B, 3, `CLS_SMUL_IMM, 6'h17);
      `CHK(opImm, 16'hFF80);
      op(48'h5678_1234_0669, 6, `CLS_SMUL_IMM, 6'h1C);
      `CHK({opDisp, opImm}, 32'h1234_5678);
      op(48'hF0_4629, 3, `CLS_SUBTRACT, 6'h07);
      `CHK({opMemory, opDisp}, 17'h1_FFF0);
      op(48'h10_4EFF, 3, `CLS_DECREMENT, 6'h08);
      `CHK({opMod, opReg, opRm, opForm}, 11'h271);
   endtask

   task automatic t_refuse;
      bad(16'h0F, 1);
      bad(16'hC080, 2);
      bad(16'hD0F6, 2);
      bad(16'hD0FE, 2);
      bad(16'h0BD4, 2);
      op(48'h48, 1, `CLS_DECREMENT, 6'h01);
      `CHK({opMod, opReg, opRm, opForm}, 11'h604);
   endtask

   // Reset in mid-execution cuts the count and frees the decoder
   task automatic t_reset;
      send(48'hF8F7, 2);
      repeat (4) @(posedge sys_clk);
      rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      @(negedge sys_clk);
      `CHK({opValid, execBusy, execDone, byteReady, opClocks}, 10'h040);
      @(posedge sys_clk);
      op(48'h4F, 1, `CLS_DECREMENT, 6'h01);
   endtask

   initial
   begin
      rst       = 1'b1;
      byteValid = 1'b0;
      byteData  = 8'h00;
      repeat (8) @(posedge sys_clk);
      rst <= 1'b0;
      t_add_carry;
      t_sub;
      t_incdec;
      t_muldiv;
      t_adjust;
      t_fields;
      t_refuse;
      t_reset;
      test_done;
   end

   initial
   begin
      repeat (20000) @(posedge sys_clk);
      n_mismatch++;
      test_done;
   end
endmodule
